// ### cts_core.sv
/*
 Core cycle timing, timer rate selection, special register bank and
 on-chip memories (program store, data SRAM, scratchpad).
 Assumes the instruction decoder drives the request ports synchronous
 to CLK and performs all data path work; this block paces it.
*/
// Behaviour
// RULE1: Every machine cycle lasts exactly four clocks.
// RULE2: One address latch strobe pulse per machine cycle.
// RULE3: Timers advance once per twelve clocks by default.
// RULE4: A timer may be set to advance once per four clocks.
// RULE5: External data moves finish in two machine cycles, eight clocks.
// RULE6: Direct to direct moves take three machine cycles, twelve clocks.
// RULE7: Instruction cycle count normally follows its byte length.
// RULE8: Instructions last from one up to five machine cycles.
// RULE9: Results match the classic instruction set; only timing differs.
// RULE10: Legacy registers sit at standard addresses, new ones added.
// RULE11: 16KB program store, 1KB data SRAM, 256 byte scratchpad.
// RULE12: Data SRAM is reached only by external data moves, never fetched.
// RULE13: Scratchpad and data SRAM decode separately, never aliasing.
// RULE14: Each timer takes its rate from its own select bit.
// RULE15: Fixed-zero bits read constant and ignore writes.
`timescale 1ns/1ps

module cts_core
   import cts_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        SFR_RD,
   input  wire logic        SFR_WR,
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic [7:0]  SFR_WDATA,
   output      logic [7:0]  SFR_RDATA,
   output      logic        SFR_HIT,
   input  wire logic        SCR_RD,
   input  wire logic        SCR_WR,
   input  wire logic [7:0]  SCR_ADDR,
   input  wire logic [7:0]  SCR_WDATA,
   output      logic [7:0]  SCR_RDATA,
   input  wire logic        CODE_RD,
   input  wire logic [13:0] CODE_ADDR,
   output      logic [7:0]  CODE_RDATA,
   input  wire logic        PROG_WR,
   input  wire logic [13:0] PROG_ADDR,
   input  wire logic [7:0]  PROG_WDATA,
   input  wire logic        XD_RD,
   input  wire logic        XD_WR,
   input  wire logic [15:0] XD_ADDR,
   input  wire logic [7:0]  XD_WDATA,
   output      logic [7:0]  XD_RDATA,
   output      logic        XD_HIT,
   input  wire logic        INSTR_GO,
   input  wire cts_kind_t   INSTR_KIND,
   input  wire logic [1:0]  INSTR_BYTES,
   output      logic        INSTR_READY,
   output      logic        INSTR_DONE,
   output      logic        MC_END,
   output      logic        ALE,
   output      logic [2:0]  TIMER_TICK
);

   // ==========================================================
   // Register map decode

   // RULE10 standard map
   function automatic logic sfr_mapped(input logic [7:0] a);
      case (a)
         `CTS_IO_BANK0_LATCH, `CTS_STACK_POINTER,
         `CTS_DATA_PTR0_LOW, `CTS_DATA_PTR0_HIGH,
         `CTS_DATA_PTR1_LOW, `CTS_DATA_PTR1_HIGH,
         `CTS_PTR_SELECT, `CTS_POWER_CONTROL,
         `CTS_TIMER01_CONTROL, `CTS_TIMER01_MODE,
         `CTS_TIMER0_LOW, `CTS_TIMER1_LOW,
         `CTS_TIMER0_HIGH, `CTS_TIMER1_HIGH,
         `CTS_CLOCK_CONTROL, `CTS_IO_BANK1_LATCH,
         `CTS_EXT_IRQ_FLAGS, `CTS_SERIAL0_CONTROL,
         `CTS_SERIAL0_BUFFER, `CTS_IO_BANK2_LATCH,
         `CTS_IRQ_ENABLE, `CTS_SERIAL0_SLAVE_ADDR,
         `CTS_SERIAL1_SLAVE_ADDR, `CTS_IO_BANK3_LATCH,
         `CTS_IRQ_PRIORITY, `CTS_SERIAL0_ADDR_MASK,
         `CTS_SERIAL1_ADDR_MASK, `CTS_SERIAL1_CONTROL,
         `CTS_SERIAL1_BUFFER, `CTS_CODE_SPACE_LIMIT,
         `CTS_POWER_MGMT, `CTS_IRQ_SERIAL_ACTIVITY,
         `CTS_TIMED_UNLOCK, `CTS_TIMER2_CONTROL,
         `CTS_TIMER2_MODE, `CTS_TIMER2_RELOAD_LOW,
         `CTS_TIMER2_RELOAD_HIGH, `CTS_TIMER2_COUNT_LOW,
         `CTS_TIMER2_COUNT_HIGH, `CTS_PROGRAM_FLAGS,
         `CTS_WATCHDOG_CONTROL, `CTS_ARITH_RESULT_REG,
         `CTS_EXT_IRQ_ENABLE2, `CTS_MUL_DIV_AUX_REG,
         `CTS_EXT_IRQ_PRIORITY2: sfr_mapped = 1'b1;
         default: sfr_mapped = 1'b0;
      endcase
   endfunction

   // RULE15 fixed-zero bits
   function automatic logic [7:0] sfr_fixed(input logic [7:0] a);
      case (a)
         `CTS_PTR_SELECT:        sfr_fixed = `CTS_FIX_PTR_SELECT;
         `CTS_POWER_CONTROL:     sfr_fixed = `CTS_FIX_POWER_CONTROL;
         `CTS_CODE_SPACE_LIMIT:  sfr_fixed = `CTS_FIX_CODE_LIMIT;
         `CTS_POWER_MGMT:        sfr_fixed = `CTS_FIX_POWER_MGMT;
         `CTS_TIMER2_MODE:       sfr_fixed = `CTS_FIX_TIMER2_MODE;
         `CTS_IRQ_PRIORITY:      sfr_fixed = `CTS_FIX_IRQ_PRIORITY;
         `CTS_EXT_IRQ_ENABLE2,
         `CTS_EXT_IRQ_PRIORITY2: sfr_fixed = `CTS_FIX_EXT_IRQ2;
         default:                sfr_fixed = 8'h00;
      endcase
   endfunction

   // Port latches come out of reset high, the rest cleared
   function automatic cts_state_t reset_state();
      cts_state_t s;
      s = '0;
      s.sfr[`CTS_IO_BANK0_LATCH & 8'h7f] = `CTS_IO_LATCH_RESET;
      s.sfr[`CTS_IO_BANK1_LATCH & 8'h7f] = `CTS_IO_LATCH_RESET;
      s.sfr[`CTS_IO_BANK2_LATCH & 8'h7f] = `CTS_IO_LATCH_RESET;
      s.sfr[`CTS_IO_BANK3_LATCH & 8'h7f] = `CTS_IO_LATCH_RESET;
      return s;
   endfunction

   localparam cts_state_t RESET_STATE = reset_state();

   // ==========================================================
   // Instruction length in machine cycles

   function automatic logic [2:0] mcycles_of(input cts_kind_t k,
                                             input logic [1:0] b);
      case (k)
         // RULE5 two cycles
         CTS_IK_XMOVE:   mcycles_of = `CTS_XMOVE_MCYCLES;
         // RULE6 three cycles
         CTS_IK_DIR_DIR: mcycles_of = `CTS_DIR_DIR_MCYCLES;
         // RULE8 longest five
         CTS_IK_LONG:    mcycles_of = `CTS_LONG_MCYCLES;
         // RULE7 one per byte
         CTS_IK_BYTES:   mcycles_of = (b == 2'h0) ? 3'h1 : {1'b0, b};
         default:        mcycles_of = 3'h1;
      endcase
   endfunction

   // ==========================================================
   // State and memories

   cts_state_t   st_reg;
   cts_state_t   st_next;
   cts_sfr_req_t req;
   logic [7:0]   sfr_idx_fix;
   logic [7:0]   clk_ctl;
   logic         xd_in_sram;

   // RULE11 memory sizes
   logic [7:0] code_mem    [`CTS_CODE_BYTES];
   logic [7:0] xram_mem    [`CTS_XRAM_BYTES];
   logic [7:0] scratch_mem [`CTS_SCRATCH_BYTES];

   assign req         = '{rd: SFR_RD, wr: SFR_WR, addr: SFR_ADDR, wdata: SFR_WDATA};
   assign sfr_idx_fix = sfr_fixed(req.addr);
   assign clk_ctl     = st_reg.sfr[`CTS_CLOCK_CONTROL & 8'h7f];

   // RULE13 separate decode
   assign xd_in_sram = (XD_ADDR[15:10] == 6'h00);

   // ==========================================================
   // Next state

   always_comb begin
      st_next        = st_reg;
      st_next.ale    = 1'b0;
      st_next.mc_end = 1'b0;
      st_next.done   = 1'b0;
      st_next.tick   = 3'h0;

      // RULE1 four-clock cycle
      st_next.phase = st_reg.phase + 2'h1;
      if (st_reg.phase == 2'(`CTS_CLKS_PER_MCYCLE - 1)) begin
         st_next.mc_end = 1'b1;
         // RULE2 one strobe
         st_next.ale = 1'b1;
      end

      // RULE3 twelve-clock prescale
      if (st_reg.slow_cnt == 4'(`CTS_CLKS_PER_SLOW_TICK - 1)) begin
         st_next.slow_cnt = 4'h0;
      end else begin
         st_next.slow_cnt = st_reg.slow_cnt + 4'h1;
      end

      // RULE14 per-timer select
      for (int i = 0; i < 3; i++) begin
         // RULE4 fast rate
         if (clk_ctl[`CTS_T0_FAST_BIT + i]) begin
            st_next.tick[i] = (st_reg.phase == 2'(`CTS_CLKS_PER_MCYCLE - 1));
         end else begin
            st_next.tick[i] = (st_reg.slow_cnt == 4'(`CTS_CLKS_PER_SLOW_TICK - 1));
         end
      end

      // Start is only taken on the last clock of a machine cycle, so
      // the instruction always owns whole machine cycles
      if (INSTR_GO && INSTR_READY) begin
         st_next.busy     = 1'b1;
         st_next.cyc_left = mcycles_of(INSTR_KIND, INSTR_BYTES);
      end else if (st_reg.busy && st_reg.phase == 2'(`CTS_CLKS_PER_MCYCLE - 1)) begin
         // RULE9 timing only
         if (st_reg.cyc_left == 3'h1) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
         st_next.cyc_left = st_reg.cyc_left - 3'h1;
      end

      // RULE10 register reads
      if (req.rd) begin
         if (req.addr[7] && sfr_mapped(req.addr)) begin
            // RULE15 constant bits
            st_next.sfr_rdata = st_reg.sfr[req.addr[6:0]] & ~sfr_idx_fix;
         end else begin
            st_next.sfr_rdata = 8'h00;
         end
      end
      if (req.wr && req.addr[7] && sfr_mapped(req.addr)) begin
         // RULE15 writes ignored
         st_next.sfr[req.addr[6:0]] = req.wdata & ~sfr_idx_fix;
      end

      // RULE13 scratchpad port
      if (SCR_RD) begin
         st_next.scr_rdata = scratch_mem[SCR_ADDR];
      end
      // RULE12 fetch from program store only
      if (CODE_RD) begin
         st_next.code_rdata = code_mem[CODE_ADDR];
      end
      // RULE12 data SRAM via data moves
      if (XD_RD) begin
         st_next.xd_rdata = xd_in_sram ? xram_mem[XD_ADDR[9:0]] : 8'h00;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Memory arrays carry no reset; their contents are undefined at power-up
   always_ff @(posedge CLK) begin
      if (SCR_WR) begin
         scratch_mem[SCR_ADDR] <= SCR_WDATA;
      end
      if (XD_WR && xd_in_sram) begin
         xram_mem[XD_ADDR[9:0]] <= XD_WDATA;
      end
      if (PROG_WR) begin
         code_mem[PROG_ADDR] <= PROG_WDATA;
      end
   end

   // ==========================================================
   // Outputs

   assign INSTR_READY = !st_reg.busy && (st_reg.phase == 2'(`CTS_CLKS_PER_MCYCLE - 1));
   assign SFR_HIT     = SFR_ADDR[7] && sfr_mapped(SFR_ADDR);
   assign XD_HIT      = xd_in_sram;
   assign SFR_RDATA   = st_reg.sfr_rdata;
   assign SCR_RDATA   = st_reg.scr_rdata;
   assign CODE_RDATA  = st_reg.code_rdata;
   assign XD_RDATA    = st_reg.xd_rdata;
   assign INSTR_DONE  = st_reg.done;
   assign MC_END      = st_reg.mc_end;
   assign ALE         = st_reg.ale;
   assign TIMER_TICK  = st_reg.tick;

endmodule

// ### cts_core_props.sv
/*
 Checker for cts_core: cycle pacing, instruction lengths, timer rates
 and register bank reads.
 Assumes it is bound to cts_core and sees only its ports.
*/
`timescale 1ns/1ps

module cts_core_props
   import cts_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RST_B,
   input wire logic       SFR_RD,
   input wire logic       SFR_WR,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       SFR_HIT,
   input wire logic       XD_RD,
   input wire logic [15:0] XD_ADDR,
   input wire logic [7:0] XD_RDATA,
   input wire logic       XD_HIT,
   input wire logic       INSTR_GO,
   input wire cts_kind_t  INSTR_KIND,
   input wire logic [1:0] INSTR_BYTES,
   input wire logic       INSTR_READY,
   input wire logic       INSTR_DONE,
   input wire logic       MC_END,
   input wire logic       ALE,
   input wire logic [2:0] TIMER_TICK
);
   // ==========================================================
   // Shadow of the timer fast-select bits
   logic [2:0] fast_reg;
   logic       take;

   assign take = INSTR_GO && INSTR_READY;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fast_reg <= 3'h0;
      end else if (SFR_WR && SFR_ADDR == 8'h8e) begin
         fast_reg <= SFR_WDATA[5:3];
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // ==========================================================
   // Properties
   mc_four_a: assert property (MC_END |=> !MC_END [*3] ##1 MC_END)
      else $error("machine cycle is not four clocks");
   ale_pulse_a: assert property ($rose(ALE) |-> MC_END ##1 !ALE)
      else $error("strobe not one pulse per cycle");
   xmove_len_a: assert property (take && INSTR_KIND == CTS_IK_XMOVE
      |=> !INSTR_DONE [*8] ##1 INSTR_DONE) else $error("external move not eight clocks");
   dirdir_len_a: assert property (take && INSTR_KIND == CTS_IK_DIR_DIR
      |=> !INSTR_DONE [*8] ##1 !INSTR_DONE [*4] ##1 INSTR_DONE)
      else $error("direct move not twelve clocks");
   // Done is a registered pulse, so it is sampled one edge after the last cycle ends
   bytes_len_a: assert property (take && INSTR_KIND == CTS_IK_BYTES
      && INSTR_BYTES == 2'h3 |-> ##13 INSTR_DONE) else $error("three byte length wrong");
   long_len_a: assert property (take && INSTR_KIND == CTS_IK_LONG |-> ##21 INSTR_DONE)
      else $error("long instruction not five cycles");
   slow_tick_a: assert property (TIMER_TICK[0] && !fast_reg[0] && !$past(fast_reg[0])
      |=> (!TIMER_TICK[0] || fast_reg[0]) [*8] ##1 (!TIMER_TICK[0] || fast_reg[0]) [*3]
      ##1 (TIMER_TICK[0] || fast_reg[0]))
      else $error("slow timer rate wrong");
   fast_tick_a: assert property (MC_END && fast_reg[1] && $past(fast_reg[1])
      |-> TIMER_TICK[1]) else $error("fast timer missed a cycle");
   own_select_a: assert property (TIMER_TICK[2] && !fast_reg[2] && !$past(fast_reg[2])
      |=> (!TIMER_TICK[2] || fast_reg[2]) [*8]) else $error("timer two rate not its own");
   fixed_zero_a: assert property (SFR_RD && SFR_ADDR == 8'h86
      |=> SFR_RDATA[7:1] == 7'h00) else $error("fixed bits not zero");
   map_hit_a: assert property (SFR_ADDR == 8'h8e |-> SFR_HIT)
      else $error("mapped register not decoded");
   xd_window_a: assert property (XD_HIT == (XD_ADDR < 16'h0400))
      else $error("data SRAM window wrong");
   xd_outside_a: assert property (XD_RD && !XD_HIT |=> XD_RDATA == 8'h00)
      else $error("outside read not zero");
endmodule

bind cts_core cts_core_props u_props (.CLK, .RST_B, .SFR_RD, .SFR_WR, .SFR_ADDR,
   .SFR_WDATA, .SFR_RDATA, .SFR_HIT, .XD_RD, .XD_ADDR, .XD_RDATA, .XD_HIT, .INSTR_GO,
   .INSTR_KIND, .INSTR_BYTES, .INSTR_READY, .INSTR_DONE, .MC_END, .ALE, .TIMER_TICK);

// ### cts_pkg.sv
/*
 Types for the core timing and register bank.
 Assumes cts_regs.svh is on the include path.
*/
package cts_pkg;
`include "cts_regs.svh"

   // ==========================================================
   // Instruction timing classes
   typedef enum logic [1:0] {
      CTS_IK_BYTES,
      CTS_IK_XMOVE,
      CTS_IK_DIR_DIR,
      CTS_IK_LONG
   } cts_kind_t;

   // ==========================================================
   // Register access request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cts_sfr_req_t;

   // ==========================================================
   // Whole state of the core
   typedef struct packed {
      logic [1:0]        phase;
      logic [3:0]        slow_cnt;
      logic              ale;
      logic              mc_end;
      logic [2:0]        tick;
      logic              busy;
      logic [2:0]        cyc_left;
      logic              done;
      logic [7:0]        sfr_rdata;
      logic [7:0]        scr_rdata;
      logic [7:0]        code_rdata;
      logic [7:0]        xd_rdata;
      logic [127:0][7:0] sfr;
   } cts_state_t;

endpackage

// ### cts_regs.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the core timing and register bank.
 Assumes it is included by the package only; the core uses its macros without including it.
*/
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

// ==========================================================
// Register offsets in direct register space
`define CTS_IO_BANK0_LATCH      8'h80
`define CTS_STACK_POINTER       8'h81
`define CTS_DATA_PTR0_LOW       8'h82
`define CTS_DATA_PTR0_HIGH      8'h83
`define CTS_DATA_PTR1_LOW       8'h84
`define CTS_DATA_PTR1_HIGH      8'h85
`define CTS_PTR_SELECT          8'h86
`define CTS_POWER_CONTROL       8'h87
`define CTS_TIMER01_CONTROL     8'h88
`define CTS_TIMER01_MODE        8'h89
`define CTS_TIMER0_LOW          8'h8a
`define CTS_TIMER1_LOW          8'h8b
`define CTS_TIMER0_HIGH         8'h8c
`define CTS_TIMER1_HIGH         8'h8d
`define CTS_CLOCK_CONTROL       8'h8e
`define CTS_IO_BANK1_LATCH      8'h90
`define CTS_EXT_IRQ_FLAGS       8'h91
`define CTS_SERIAL0_CONTROL     8'h98
`define CTS_SERIAL0_BUFFER      8'h99
`define CTS_IO_BANK2_LATCH      8'ha0
`define CTS_IRQ_ENABLE          8'ha8
`define CTS_SERIAL0_SLAVE_ADDR  8'ha9
`define CTS_SERIAL1_SLAVE_ADDR  8'haa
`define CTS_IO_BANK3_LATCH      8'hb0
`define CTS_IRQ_PRIORITY        8'hb8
`define CTS_SERIAL0_ADDR_MASK   8'hb9
`define CTS_SERIAL1_ADDR_MASK   8'hba
`define CTS_SERIAL1_CONTROL     8'hc0
`define CTS_SERIAL1_BUFFER      8'hc1
`define CTS_CODE_SPACE_LIMIT    8'hc2
`define CTS_POWER_MGMT          8'hc4
`define CTS_IRQ_SERIAL_ACTIVITY 8'hc5
`define CTS_TIMED_UNLOCK        8'hc7
`define CTS_TIMER2_CONTROL      8'hc8
`define CTS_TIMER2_MODE         8'hc9
`define CTS_TIMER2_RELOAD_LOW   8'hca
`define CTS_TIMER2_RELOAD_HIGH  8'hcb
`define CTS_TIMER2_COUNT_LOW    8'hcc
`define CTS_TIMER2_COUNT_HIGH   8'hcd
`define CTS_PROGRAM_FLAGS       8'hd0
`define CTS_WATCHDOG_CONTROL    8'hd8
`define CTS_ARITH_RESULT_REG    8'he0
`define CTS_EXT_IRQ_ENABLE2     8'he8
`define CTS_MUL_DIV_AUX_REG     8'hf0
`define CTS_EXT_IRQ_PRIORITY2   8'hf8

// ==========================================================
// Fixed-zero bit masks
`define CTS_FIX_PTR_SELECT      8'hfe
`define CTS_FIX_POWER_CONTROL   8'h30
`define CTS_FIX_CODE_LIMIT      8'hf8
`define CTS_FIX_POWER_MGMT      8'h10
`define CTS_FIX_TIMER2_MODE     8'hfc
`define CTS_FIX_IRQ_PRIORITY    8'h80
`define CTS_FIX_EXT_IRQ2        8'he0

// ==========================================================
// Fields of clock_control
`define CTS_T0_FAST_BIT         3
`define CTS_T1_FAST_BIT         4
`define CTS_T2_FAST_BIT         5

// ==========================================================
// Reset values and timing
`define CTS_IO_LATCH_RESET      8'hff
`define CTS_CLKS_PER_MCYCLE     4
`define CTS_CLKS_PER_SLOW_TICK  12
`define CTS_XMOVE_MCYCLES       3'h2
`define CTS_DIR_DIR_MCYCLES     3'h3
`define CTS_LONG_MCYCLES        3'h5
`define CTS_CODE_BYTES          16384
`define CTS_XRAM_BYTES          1024
`define CTS_SCRATCH_BYTES       256

`endif

// ### testbench.sv
/*
 Self-checking bench for cts_core.
 Assumes the checker file is compiled with it; inputs change at falling edges.
*/
`timescale 1ns/1ps

module testbench
   import cts_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b, sfr_rd, sfr_wr, scr_rd, scr_wr, code_rd, prog_wr, xd_rd, xd_wr;
   logic        instr_go, sfr_hit, xd_hit, instr_ready, instr_done, mc_end, ale;
   logic [7:0]  sfr_addr, sfr_wdata, scr_addr, scr_wdata, prog_wdata, xd_wdata;
   logic [7:0]  sfr_rdata, scr_rdata, code_rdata, xd_rdata;
   logic [13:0] code_addr, prog_addr;
   logic [15:0] xd_addr;
   logic [1:0]  instr_bytes;
   logic [2:0]  timer_tick;
   cts_kind_t   instr_kind;
   int          err_count = 0;
   int          cmp_count = 0;

   always #25 clk = ~clk;

   cts_core u_dut (.CLK(clk), .RST_B(rst_b), .SFR_RD(sfr_rd), .SFR_WR(sfr_wr),
      .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit),
      .SCR_RD(scr_rd), .SCR_WR(scr_wr), .SCR_ADDR(scr_addr), .SCR_WDATA(scr_wdata),
      .SCR_RDATA(scr_rdata), .CODE_RD(code_rd), .CODE_ADDR(code_addr),
      .CODE_RDATA(code_rdata), .PROG_WR(prog_wr), .PROG_ADDR(prog_addr),
      .PROG_WDATA(prog_wdata), .XD_RD(xd_rd), .XD_WR(xd_wr), .XD_ADDR(xd_addr),
      .XD_WDATA(xd_wdata), .XD_RDATA(xd_rdata), .XD_HIT(xd_hit), .INSTR_GO(instr_go),
      .INSTR_KIND(instr_kind), .INSTR_BYTES(instr_bytes), .INSTR_READY(instr_ready),
      .INSTR_DONE(instr_done), .MC_END(mc_end), .ALE(ale), .TIMER_TICK(timer_tick));

   // ==========================================================
   // Shared tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic sfr_check(input logic [7:0] a, input logic [7:0] exp);
      sfr_rd = 1'b1;
      sfr_addr = a;
      @(negedge clk);
      sfr_rd = 1'b0;
      cmp(sfr_rdata, exp);
   endtask

   task automatic test_done();
      if (err_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_registers();
      logic [7:0] a [6] = '{8'h86, 8'h87, 8'hc9, 8'he8, 8'hb8, 8'h8f};
      logic [7:0] e [6] = '{8'h01, 8'hcf, 8'h03, 8'h1f, 8'h7f, 8'h00};
      sfr_check(8'h80, 8'hff);
      sfr_check(8'h8e, 8'h00);
      for (int i = 0; i < 6; i++) begin
         sfr_write(a[i], 8'hff);
         sfr_check(a[i], e[i]);
      end
   endtask

   task automatic t_mcycle();
      int n_mc = 0;
      int n_ale = 0;
      repeat (40) begin
         @(negedge clk);
         n_mc += (mc_end === 1'b1);
         n_ale += (ale === 1'b1 && mc_end === 1'b1);
      end
      cmp(8'(n_mc), 8'h0a);
      cmp(8'(n_ale), 8'h0a);
   endtask

   // Waits are bounded so a stuck sequencer reads as a wrong count
   task automatic run_instr(input cts_kind_t k, input logic [1:0] b, input logic [7:0] exp);
      int n = 0;
      while (instr_ready !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      instr_go = 1'b1;
      instr_kind = k;
      instr_bytes = b;
      @(negedge clk);
      instr_go = 1'b0;
      n = 0;
      while (instr_done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      cmp(8'(n), exp);
   endtask

   task automatic t_timers(input logic [7:0] sel, input logic [7:0] e0, e1, e2);
      int n [3] = '{0, 0, 0};
      sfr_write(8'h8e, sel);
      repeat (8) @(negedge clk);
      repeat (48) begin
         @(negedge clk);
         for (int i = 0; i < 3; i++) begin
            n[i] += (timer_tick[i] === 1'b1);
         end
      end
      cmp(8'(n[0]), e0);
      cmp(8'(n[1]), e1);
      cmp(8'(n[2]), e2);
   endtask

   task automatic t_memories();
      {scr_wr, xd_wr, prog_wr} = 3'h7;
      {scr_addr, scr_wdata, xd_addr, xd_wdata} = {8'h10, 8'h5a, 16'h0010, 8'ha5};
      {prog_addr, prog_wdata} = {14'h0010, 8'h11};
      @(negedge clk);
      scr_wr = 1'b0;
      {xd_addr, prog_addr, prog_wdata} = {16'h0410, 14'h3fff, 8'hc3};
      @(negedge clk);
      {xd_wr, prog_wr, scr_rd, xd_rd, code_rd} = 5'h07;
      {code_addr, xd_addr} = {14'h0010, 16'h0010};
      @(negedge clk);
      cmp(scr_rdata, 8'h5a);
      cmp(xd_rdata, 8'ha5);
      cmp(code_rdata, 8'h11);
      {xd_addr, code_addr} = {16'h0410, 14'h3fff};
      @(negedge clk);
      {scr_rd, xd_rd, code_rd} = 3'h0;
      cmp(xd_rdata, 8'h00);
      cmp(code_rdata, 8'hc3);
      cmp({7'h00, xd_hit}, 8'h00);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      {rst_b, sfr_rd, sfr_wr, scr_rd, scr_wr, code_rd, prog_wr, xd_rd, xd_wr, instr_go} = '0;
      {sfr_addr, sfr_wdata, scr_addr, scr_wdata, prog_wdata, xd_wdata} = '0;
      {code_addr, prog_addr, xd_addr, instr_bytes} = '0;
      instr_kind = CTS_IK_BYTES;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      t_registers();
      t_mcycle();
      run_instr(CTS_IK_BYTES, 2'h1, 8'h04);
      run_instr(CTS_IK_BYTES, 2'h2, 8'h08);
      run_instr(CTS_IK_BYTES, 2'h3, 8'h0c);
      run_instr(CTS_IK_XMOVE, 2'h1, 8'h08);
      run_instr(CTS_IK_DIR_DIR, 2'h3, 8'h0c);
      run_instr(CTS_IK_LONG, 2'h1, 8'h14);
      t_timers(8'h00, 8'h04, 8'h04, 8'h04);
      t_timers(8'h20, 8'h04, 8'h04, 8'h0c);
      t_timers(8'h10, 8'h04, 8'h0c, 8'h04);
      t_timers(8'h08, 8'h0c, 8'h04, 8'h04);
      t_memories();
      test_done();
   end

   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule
